// ===== design/lpes_event_select.sv
// lpes_event_select: picks the occurrence pulses that feed one event counter.
// assumes synchronous occurrence inputs from both cpus of the l2 cluster,
// an axi4-lite master on the register port and one clock domain.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`default_nettype none

// Summary of operation
// - code 14H qualifier 01H counts each cycle the divider is busy
// - code 21H counts cycles the l2 address path is in use
// - code 22H counts l2 data path cycles moving hit data to l1
// - a full line transfer on 22H adds two in total
// - code 24H counts l2 line allocations
// - code 25H counts dirty l1 data writebacks into the l2
// - code 26H counts every l2 eviction
// - code 27H counts evictions of dirty l2 lines
// - code 28H counts cacheable instruction line requests, no uncached or itlb
// - code 29H counts l2 reads from l1 data and prefetchers
// - code 2AH counts stores missing l1 data that ask the l2
// - code 2BH counts locked accesses missing the l1 data cache
// - code 2EH counts all completed l2 requests
// - 2EH with 41H counts local demand requests that miss l2
// - 2EH with 4FH counts all local demand requests
// - 41H and 4FH selections are fixed, flagged as architectural
// - qualifier picks local cpu only or both cpus
// - qualifier picks demand, hardware prefetch, or both
// - qualifier filters by line coherence state
module lpes_event_select
	import lpes_pkg::*;
(
	input  wire logic             aclk,          // clock, 250 MHz
	input  wire logic             aresetn,       // sync reset, low
	input  wire logic             ce,            // clock enable
	input  wire logic             div_busy,      // divider busy this cycle
	input  wire lpes_occ_t [1:0]  occ,           // [0] local, [1] peer
	input  wire logic [7:0]       s_axi_awaddr,  // write address
	input  wire logic             s_axi_awvalid, // write address valid
	output logic                  s_axi_awready, // write address ready
	input  wire logic [31:0]      s_axi_wdata,   // write data
	input  wire logic [3:0]       s_axi_wstrb,   // byte enables
	input  wire logic             s_axi_wvalid,  // write data valid
	output logic                  s_axi_wready,  // write data ready
	output logic [1:0]            s_axi_bresp,   // write response
	output logic                  s_axi_bvalid,  // write response valid
	input  wire logic             s_axi_bready,  // write response ready
	input  wire logic [7:0]       s_axi_araddr,  // read address
	input  wire logic             s_axi_arvalid, // read address valid
	output logic                  s_axi_arready, // read address ready
	output logic [31:0]           s_axi_rdata,   // read data
	output logic [1:0]            s_axi_rresp,   // read response
	output logic                  s_axi_rvalid,  // read data valid
	input  wire logic             s_axi_rready,  // read data ready
	output logic [2:0]            sel_incr,      // increment this cycle
	output logic                  sel_defined    // selection is defined
);

	// ================================================================
	// qualifier helpers

	function automatic logic [1:0] cpu_mask(input logic [1:0] f);
		case (f)
			LPES_CPU_SELF: cpu_mask = 2'h1;
			LPES_CPU_BOTH: cpu_mask = 2'h3;
			default:       cpu_mask = 2'h0;
		endcase
	endfunction

	function automatic logic pf_ok(input logic [1:0] f, input logic is_pf);
		case (f)
			LPES_PF_DEMAND: pf_ok = !is_pf;
			LPES_PF_HW:     pf_ok = is_pf;
			LPES_PF_ALL:    pf_ok = 1'b1;
			default:        pf_ok = 1'b0;
		endcase
	endfunction

	function automatic logic st_ok(input logic [3:0] m, input logic [3:0] st);
		st_ok = |(m & st);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = r;
	endfunction

	// ================================================================
	// contribution of one cpu to the selected event, 0 to 2

	function automatic logic [1:0] cpu_hit(input logic [7:0] ev,
		input logic [7:0] um, input lpes_occ_t o);
		logic [1:0] pf;
		logic [3:0] m;
		logic [1:0] h;
		pf = um[LPES_UM_PF_LSB +: 2];
		m  = um[3:0];
		h  = 2'h0;
		case (ev)
			LPES_EV_ADDR_PATH: begin
				h = {1'b0, o.addr_busy};
			end
			LPES_EV_DATA_PATH: begin
				// a full line counts two, a half line one
				if (o.data_line) begin
					h = 2'h2;
				end else begin
					h = {1'b0, o.data_half};
				end
			end
			LPES_EV_FILLS: begin
				h = {1'b0, o.fill && pf_ok(pf, o.fill_pf)};
			end
			LPES_EV_L1_WB: begin
				h = {1'b0, o.l1_wb};
			end
			LPES_EV_EVICT: begin
				h = {1'b0, o.evict && pf_ok(pf, o.evict_pf)};
			end
			LPES_EV_DEVICT: begin
				h = {1'b0, o.evict && o.evict_dirty
					&& pf_ok(pf, o.evict_pf)};
			end
			LPES_EV_IFETCH: begin
				// uncached fetches and itlb walks are masked out here
				h = {1'b0, o.ifetch && !o.ifetch_unc && !o.ifetch_itlb
					&& st_ok(m, o.ifetch_st)};
			end
			LPES_EV_READ: begin
				h = {1'b0, o.rd && pf_ok(pf, o.rd_pf)
					&& st_ok(m, o.rd_st)};
			end
			LPES_EV_STORE: begin
				h = {1'b0, o.st && st_ok(m, o.st_st)};
			end
			LPES_EV_LOCK: begin
				h = {1'b0, o.lock && o.lock_l1_miss
					&& st_ok(m, o.lock_st)};
			end
			LPES_EV_REQ: begin
				// 41H: demand, local, invalid state = l2 miss
				// 4FH: demand, local, any state
				h = {1'b0, o.rq && pf_ok(pf, o.rq_pf)
					&& st_ok(m, o.rq_st)};
			end
			default: begin
				h = 2'h0;
			end
		endcase
		cpu_hit = h;
	endfunction

	// ================================================================
	// state

	lpes_regs_t state_ff;
	lpes_regs_t nxt_state;

	logic [1:0] sel_cpus;
	logic       l2_code;
	logic       arch_sel;
	logic       sel_ok;
	logic [2:0] incr_now;
	logic       aw_take;
	logic       w_take;
	logic       ar_take;
	logic       do_write;
	logic [31:0] rd_word;

	// ================================================================
	// selection decode

	always_comb begin
		sel_cpus = cpu_mask(state_ff.um[LPES_UM_CPU_LSB +: 2]);
		l2_code  = (state_ff.ev >= LPES_EV_ADDR_PATH)
			&& (state_ff.ev <= LPES_EV_REQ)
			&& (state_ff.ev != 8'h23)
			&& (state_ff.ev != 8'h2C)
			&& (state_ff.ev != 8'h2D);
		// fixed encodings, kept identical whatever the cluster size
		arch_sel = (state_ff.ev == LPES_EV_REQ)
			&& ((state_ff.um == LPES_UM_LOCAL_MISS)
			|| (state_ff.um == LPES_UM_LOCAL_ALL));
		if (state_ff.ev == LPES_EV_DIV_BUSY) begin
			sel_ok = (state_ff.um == LPES_UM_DIV);
		end else begin
			sel_ok = l2_code && (sel_cpus != 2'h0);
		end
	end

	// ================================================================
	// increment sum over both cpus

	always_comb begin
		incr_now = 3'h0;
		if (state_ff.ev == LPES_EV_DIV_BUSY) begin
			// divider is private to the local cpu
			if (sel_ok && div_busy) begin
				incr_now = 3'h1;
			end
		end else if (sel_ok) begin
			for (int i = 0; i < 2; i++) begin
				if (sel_cpus[i]) begin
					incr_now = incr_now
						+ {1'b0, cpu_hit(state_ff.ev, state_ff.um, occ[i])};
				end
			end
		end
	end

	// ================================================================
	// axi handshakes

	always_comb begin
		s_axi_awready = ce && (state_ff.wr_st == LPES_WR_COLLECT)
			&& !state_ff.aw_held;
		s_axi_wready  = ce && (state_ff.wr_st == LPES_WR_COLLECT)
			&& !state_ff.w_held;
		s_axi_arready = ce && (state_ff.rd_st == LPES_RD_IDLE);
		aw_take  = s_axi_awready && s_axi_awvalid;
		w_take   = s_axi_wready && s_axi_wvalid;
		ar_take  = s_axi_arready && s_axi_arvalid;
		do_write = (state_ff.wr_st == LPES_WR_COLLECT)
			&& state_ff.aw_held && state_ff.w_held;
	end

	// ================================================================
	// read mux

	always_comb begin
		rd_word = 32'h0;
		case (s_axi_araddr)
			LPES_SELECT_OFFS: begin
				rd_word[LPES_SEL_EV_LSB +: 8] = state_ff.ev;
				rd_word[LPES_SEL_UM_LSB +: 8] = state_ff.um;
				rd_word[LPES_SEL_EN_BIT]      = state_ff.en;
			end
			LPES_COUNT_OFFS: begin
				rd_word = state_ff.cnt;
			end
			LPES_STATUS_OFFS: begin
				rd_word[LPES_STAT_VALID_BIT]    = sel_ok;
				rd_word[LPES_STAT_ARCH_BIT]     = arch_sel;
				rd_word[LPES_STAT_INCR_LSB +: 3] = state_ff.incr;
			end
			default: begin
				rd_word = 32'h0;
			end
		endcase
	end

	// ================================================================
	// next state

	always_comb begin
		logic [31:0] sel_word;
		sel_word = 32'h0;
		nxt_state = state_ff;
		sel_word[LPES_SEL_EV_LSB +: 8] = state_ff.ev;
		sel_word[LPES_SEL_UM_LSB +: 8] = state_ff.um;
		sel_word[LPES_SEL_EN_BIT]      = state_ff.en;

		// registered increment; counting runs only while enabled
		nxt_state.incr = state_ff.en ? incr_now : 3'h0;
		if (state_ff.en) begin
			nxt_state.cnt = state_ff.cnt
				+ {{(LPES_CNT_W-3){1'b0}}, state_ff.incr};
		end

		if (aw_take) begin
			nxt_state.aw_held = 1'b1;
			nxt_state.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			nxt_state.w_held = 1'b1;
			nxt_state.wdata  = s_axi_wdata;
			nxt_state.wstrb  = s_axi_wstrb;
		end

		case (state_ff.wr_st)
			LPES_WR_COLLECT: begin
				if (do_write) begin
					nxt_state.aw_held = 1'b0;
					nxt_state.w_held  = 1'b0;
					nxt_state.wr_st   = LPES_WR_RESP;
					nxt_state.bresp   = LPES_RESP_OKAY;
					case (state_ff.aw_addr)
						LPES_SELECT_OFFS: begin
							sel_word = merge(sel_word, state_ff.wdata,
								state_ff.wstrb);
							nxt_state.ev = sel_word[LPES_SEL_EV_LSB +: 8];
							nxt_state.um = sel_word[LPES_SEL_UM_LSB +: 8];
							nxt_state.en = sel_word[LPES_SEL_EN_BIT];
							// a new selection drops any increment in flight
							nxt_state.incr = 3'h0;
						end
						LPES_COUNT_OFFS: begin
							// software load beats the increment this cycle
							nxt_state.cnt = merge(state_ff.cnt, state_ff.wdata,
								state_ff.wstrb);
						end
						LPES_STATUS_OFFS: begin
							nxt_state.bresp = LPES_RESP_OKAY;
						end
						default: begin
							nxt_state.bresp = LPES_RESP_SLVERR;
						end
					endcase
				end
			end
			LPES_WR_RESP: begin
				if (s_axi_bready) begin
					nxt_state.wr_st = LPES_WR_COLLECT;
				end
			end
			default: begin
				nxt_state.wr_st = LPES_WR_COLLECT;
			end
		endcase

		case (state_ff.rd_st)
			LPES_RD_IDLE: begin
				if (ar_take) begin
					nxt_state.rd_st = LPES_RD_DATA;
					nxt_state.rdata = rd_word;
					case (s_axi_araddr)
						LPES_SELECT_OFFS,
						LPES_COUNT_OFFS,
						LPES_STATUS_OFFS: nxt_state.rresp = LPES_RESP_OKAY;
						default:          nxt_state.rresp = LPES_RESP_SLVERR;
					endcase
				end
			end
			LPES_RD_DATA: begin
				if (s_axi_rready) begin
					nxt_state.rd_st = LPES_RD_IDLE;
				end
			end
			default: begin
				nxt_state.rd_st = LPES_RD_IDLE;
			end
		endcase
	end

	// ================================================================
	// registers; ce low freezes everything, reset still loads

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= LPES_REGS_RST;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// ================================================================
	// outputs

	always_comb begin
		s_axi_bvalid = (state_ff.wr_st == LPES_WR_RESP);
		s_axi_bresp  = state_ff.bresp;
		s_axi_rvalid = (state_ff.rd_st == LPES_RD_DATA);
		s_axi_rdata  = state_ff.rdata;
		s_axi_rresp  = state_ff.rresp;
		sel_incr     = state_ff.incr;
		sel_defined  = sel_ok;
	end

endmodule
`default_nettype wire

// ===== design/lpes_pkg.sv
// lpes_pkg: constants, types and register map of the l2 event selector.
// assumes one 250 MHz clock and an axi4-lite register port.
`default_nettype none
package lpes_pkg;
	// ================================================================
	// register map (byte addresses)
	localparam logic [7:0] LPES_SELECT_OFFS = 8'h00;
	localparam logic [7:0] LPES_COUNT_OFFS  = 8'h04;
	localparam logic [7:0] LPES_STATUS_OFFS = 8'h08;
	localparam int         LPES_ADDR_W      = 8;
	localparam int         LPES_CNT_W       = 32;
	// select register fields
	localparam int LPES_SEL_EV_LSB = 0;
	localparam int LPES_SEL_UM_LSB = 8;
	localparam int LPES_SEL_EN_BIT = 16;
	// status register fields
	localparam int LPES_STAT_VALID_BIT = 0;
	localparam int LPES_STAT_ARCH_BIT  = 1;
	localparam int LPES_STAT_INCR_LSB  = 4;
	// ================================================================
	// event codes and fixed qualifiers
	localparam logic [7:0] LPES_EV_DIV_BUSY  = 8'h14;
	localparam logic [7:0] LPES_EV_ADDR_PATH = 8'h21;
	localparam logic [7:0] LPES_EV_DATA_PATH = 8'h22;
	localparam logic [7:0] LPES_EV_FILLS     = 8'h24;
	localparam logic [7:0] LPES_EV_L1_WB     = 8'h25;
	localparam logic [7:0] LPES_EV_EVICT     = 8'h26;
	localparam logic [7:0] LPES_EV_DEVICT    = 8'h27;
	localparam logic [7:0] LPES_EV_IFETCH    = 8'h28;
	localparam logic [7:0] LPES_EV_READ      = 8'h29;
	localparam logic [7:0] LPES_EV_STORE     = 8'h2A;
	localparam logic [7:0] LPES_EV_LOCK      = 8'h2B;
	localparam logic [7:0] LPES_EV_REQ       = 8'h2E;
	localparam logic [7:0] LPES_UM_DIV       = 8'h01;
	localparam logic [7:0] LPES_UM_LOCAL_MISS = 8'h41;
	localparam logic [7:0] LPES_UM_LOCAL_ALL  = 8'h4F;
	// qualifier fields: [7:6] cpu scope, [5:4] request kind, [3:0] line state
	localparam int LPES_UM_CPU_LSB = 6;
	localparam int LPES_UM_PF_LSB  = 4;
	localparam logic [1:0] LPES_CPU_SELF  = 2'h1;
	localparam logic [1:0] LPES_CPU_BOTH  = 2'h3;
	localparam logic [1:0] LPES_PF_DEMAND = 2'h0;
	localparam logic [1:0] LPES_PF_HW     = 2'h1;
	localparam logic [1:0] LPES_PF_ALL    = 2'h3;
	// line state one-hot: modified, exclusive, shared, invalid (miss)
	localparam logic [3:0] LPES_ST_I = 4'h1;
	// ================================================================
	// axi responses
	localparam logic [1:0] LPES_RESP_OKAY   = 2'h0;
	localparam logic [1:0] LPES_RESP_SLVERR = 2'h2;
	// ================================================================
	// per-cpu occurrence pulses, one cycle each
	typedef struct packed {
		logic       addr_busy;
		logic       data_half;
		logic       data_line;
		logic       fill;
		logic       fill_pf;
		logic       l1_wb;
		logic       evict;
		logic       evict_pf;
		logic       evict_dirty;
		logic       ifetch;
		logic       ifetch_unc;
		logic       ifetch_itlb;
		logic [3:0] ifetch_st;
		logic       rd;
		logic       rd_pf;
		logic [3:0] rd_st;
		logic       st;
		logic [3:0] st_st;
		logic       lock;
		logic       lock_l1_miss;
		logic [3:0] lock_st;
		logic       rq;
		logic       rq_pf;
		logic [3:0] rq_st;
	} lpes_occ_t;

	typedef enum logic [0:0] {
		LPES_WR_COLLECT = 1'b0,
		LPES_WR_RESP    = 1'b1
	} lpes_wr_st_t;

	typedef enum logic [0:0] {
		LPES_RD_IDLE = 1'b0,
		LPES_RD_DATA = 1'b1
	} lpes_rd_st_t;

	typedef struct packed {
		lpes_wr_st_t            wr_st;
		lpes_rd_st_t            rd_st;
		logic                   aw_held;
		logic [LPES_ADDR_W-1:0] aw_addr;
		logic                   w_held;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic [1:0]             bresp;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [7:0]             ev;
		logic [7:0]             um;
		logic                   en;
		logic [LPES_CNT_W-1:0]  cnt;
		logic [2:0]             incr;
	} lpes_regs_t;

	localparam lpes_regs_t LPES_REGS_RST = lpes_regs_t'('0);
endpackage
`default_nettype wire

// ===== test/lpes_event_select_assertions.sv
// lpes_event_select_assertions: port-level checks of the l2 event selector.
// assumes only the selector's own ports; bound into every instance.
`default_nettype none
module lpes_sel_chk
	import lpes_pkg::*;
(
	input wire logic        aclk,          // clock
	input wire logic        aresetn,       // sync reset, low
	input wire logic        ce,            // clock enable
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic [1:0]  s_axi_bresp,   // b resp
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata,   // r data
	input wire logic [1:0]  s_axi_rresp,   // r resp
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic        s_axi_rready,  // r ready
	input wire logic [2:0]  sel_incr,      // increment
	input wire logic        sel_defined    // defined selection
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ================================================================
	// selection
	rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
		sel_incr == 3'h0 && !sel_defined && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");
	undef_quiet_a: assert property (ce && !sel_defined |=> sel_incr == 3'h0)
		else $error("undefined selection counted");
	incr_max_a: assert property (sel_incr <= 3'h4)
		else $error("increment above four");
	// ================================================================
	// register port
	ce_gate_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while clock enable low");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready ##1 ce |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == LPES_RESP_SLVERR);
	cover property (sel_incr == 3'h4);
	cover property (sel_incr == 3'h2);
endmodule
bind lpes_event_select lpes_sel_chk lpes_sel_chk_i (
	.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sel_incr(sel_incr), .sel_defined(sel_defined)
);
`default_nettype wire

// ===== test/tb_top.sv
// tb_top: self-checking bench for the l2 event selector.
// assumes lpes_pkg is compiled first; the bench drives every port itself.
`default_nettype none
module tb_top
	import lpes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            aclk = 1'b0;
	logic            aresetn = 1'b0;
	logic            ce = 1'b1;
	logic            div_busy = 1'b0;
	lpes_occ_t [1:0] occ = '0;
	logic [7:0]      awaddr = 8'h00;
	logic [7:0]      araddr = 8'h00;
	logic [31:0]     wdata = 32'h0;
	logic            awvalid = 1'b0;
	logic            wvalid = 1'b0;
	logic            bready = 1'b0;
	logic            arvalid = 1'b0;
	logic            rready = 1'b0;
	logic            awrdy, wrdy, bvalid, arrdy, rvalid, sdef;
	logic [1:0]      bresp, rresp;
	logic [31:0]     rdata;
	logic [2:0]      sincr;
	lpes_occ_t       o0 = '0;
	lpes_occ_t       o1 = '0;
	logic            dv = 1'b0;
	int              mismatches = 0;
	int              num_checks = 0;
	always #2 aclk = ~aclk;
	lpes_event_select lpes_event_select_i (
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .div_busy(div_busy), .occ(occ),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sel_incr(sincr), .sel_defined(sdef)
	);
	// ================================================================
	// tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awrdy === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wrdy === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arrdy !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// one pulse of o0, o1 and dv under the given selection
	task automatic run(input logic [7:0] ev, input logic [7:0] um, input logic [2:0] exp,
		input bit clr);
		logic [1:0] r;
		wr(LPES_SELECT_OFFS, {15'h0, 1'b1, um, ev}, r);
		@(posedge aclk);
		occ <= {o1, o0};
		div_busy <= dv;
		@(posedge aclk);
		occ <= '0;
		div_busy <= 1'b0;
		#1;
		chk("sel_incr", {29'h0, exp}, {29'h0, sincr});
		if (clr) begin
			o0 = '0;
			o1 = '0;
			dv = 1'b0;
		end
	endtask
	// ================================================================
	// tests
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		give_verdict();
	end
	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(LPES_SELECT_OFFS, d, r);
		chk("select", 32'h0, d);
		rd(LPES_COUNT_OFFS, d, r);
		chk("count", 32'h0, d);
		rd(8'h0C, d, r);
		chk("unmapped", {30'h0, LPES_RESP_SLVERR}, {30'h0, r});
		$display("test reset done");
		dv = 1'b1;
		run(LPES_EV_DIV_BUSY, LPES_UM_DIV, 3'd1, 1);
		o0.addr_busy = 1'b1;
		o1.addr_busy = 1'b1;
		run(LPES_EV_ADDR_PATH, 8'h40, 3'd1, 0);
		run(LPES_EV_ADDR_PATH, 8'h80, 3'd0, 0);
		run(LPES_EV_ADDR_PATH, 8'hC0, 3'd2, 1);
		o0.data_line = 1'b1;
		o1.data_half = 1'b1;
		run(LPES_EV_DATA_PATH, 8'h40, 3'd2, 0);
		run(LPES_EV_DATA_PATH, 8'hC0, 3'd3, 1);
		o0.fill = 1'b1;
		o1.fill = 1'b1;
		o1.fill_pf = 1'b1;
		run(LPES_EV_FILLS, 8'hC0, 3'd1, 0);
		run(LPES_EV_FILLS, 8'hD0, 3'd1, 0);
		run(LPES_EV_FILLS, 8'hF0, 3'd2, 0);
		run(LPES_EV_FILLS, 8'hE0, 3'd0, 1);
		o0.l1_wb = 1'b1;
		run(LPES_EV_L1_WB, 8'h40, 3'd1, 1);
		o0.evict = 1'b1;
		o1.evict = 1'b1;
		o1.evict_dirty = 1'b1;
		run(LPES_EV_EVICT, 8'hC0, 3'd2, 0);
		run(LPES_EV_DEVICT, 8'hC0, 3'd1, 1);
		o0.ifetch = 1'b1;
		o0.ifetch_st = LPES_ST_I;
		o1.ifetch = 1'b1;
		o1.ifetch_unc = 1'b1;
		o1.ifetch_st = LPES_ST_I;
		run(LPES_EV_IFETCH, 8'hCF, 3'd1, 0);
		run(LPES_EV_IFETCH, 8'hCE, 3'd0, 0);
		o0.ifetch_itlb = 1'b1;
		run(LPES_EV_IFETCH, 8'hCF, 3'd0, 1);
		o0.rd = 1'b1;
		o0.rd_st = 4'h2;
		o1.rd = 1'b1;
		o1.rd_pf = 1'b1;
		o1.rd_st = 4'h2;
		run(LPES_EV_READ, 8'hCF, 3'd1, 0);
		run(LPES_EV_READ, 8'hF2, 3'd2, 0);
		run(LPES_EV_READ, 8'hF4, 3'd0, 1);
		o0.st = 1'b1;
		o0.st_st = 4'h8;
		run(LPES_EV_STORE, 8'h48, 3'd1, 0);
		run(LPES_EV_STORE, 8'h47, 3'd0, 1);
		o0.lock = 1'b1;
		o0.lock_st = LPES_ST_I;
		o1.lock = 1'b1;
		o1.lock_l1_miss = 1'b1;
		o1.lock_st = LPES_ST_I;
		run(LPES_EV_LOCK, 8'hCF, 3'd1, 1);
		o0.rq = 1'b1;
		o0.rq_st = LPES_ST_I;
		o1.rq = 1'b1;
		o1.rq_st = LPES_ST_I;
		run(LPES_EV_REQ, LPES_UM_LOCAL_MISS, 3'd1, 0);
		o0.rq_pf = 1'b1;
		run(LPES_EV_REQ, LPES_UM_LOCAL_MISS, 3'd0, 0);
		run(LPES_EV_REQ, 8'hFF, 3'd2, 1);
		o0.rq = 1'b1;
		o0.rq_st = 4'h8;
		run(LPES_EV_REQ, LPES_UM_LOCAL_ALL, 3'd1, 0);
		run(LPES_EV_REQ, LPES_UM_LOCAL_MISS, 3'd0, 1);
		o0 = '1;
		o1 = '1;
		dv = 1'b1;
		run(8'h23, 8'hFF, 3'd0, 0);
		chk("sel_defined", 32'h0, {31'h0, sdef});
		run(LPES_EV_DIV_BUSY, 8'h02, 3'd0, 1);
		$display("test events done");
		wr(LPES_SELECT_OFFS, {15'h0, 1'b1, LPES_UM_LOCAL_MISS, LPES_EV_REQ}, r);
		rd(LPES_STATUS_OFFS, d, r);
		chk("status", 32'h3, d & 32'h3);
		wr(LPES_SELECT_OFFS, {15'h0, 1'b1, 8'hFF, LPES_EV_REQ}, r);
		rd(LPES_STATUS_OFFS, d, r);
		chk("status", 32'h1, d & 32'h3);
		chk("sel_defined", 32'h1, {31'h0, sdef});
		wr(LPES_STATUS_OFFS, 32'hFFFF_FFFF, r);
		chk("status write", {30'h0, LPES_RESP_OKAY}, {30'h0, r});
		$display("test status done");
		wr(LPES_SELECT_OFFS, {15'h0, 1'b1, 8'h40, LPES_EV_ADDR_PATH}, r);
		wr(LPES_COUNT_OFFS, 32'h5, r);
		@(posedge aclk);
		occ[0].addr_busy <= 1'b1;
		repeat (3) @(posedge aclk);
		occ <= '0;
		ce <= 1'b0;
		@(posedge aclk);
		#1;
		chk("arready", 32'h0, {31'h0, arrdy});
		@(posedge aclk);
		ce <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(LPES_COUNT_OFFS, d, r);
		chk("count", 32'h8, d);
		$display("test count done");
		give_verdict();
	end
endmodule
`default_nettype wire
